// *** i2c_tmo_pkg.sv ***
// Constants, register map and state codes for the two-wire slave.
// Assumes one 25 MHz pclk; APB register access with 8-bit addresses.
// Contract
// - Data bytes eight bits, MSB first
// - Receiver drives low acknowledge after each byte
// - Transmitter releases data line on no acknowledge
// - Bytes pass through the serial data buffer
// - Receiver drives ack-to-send bit on ninth clock
// - Transmitter checks master acknowledge before next byte
// - Clock held low until buffer serviced
// - Time-out counter starts on address match
// - Serial clock falling edge clears counter
// - Time-out when count exceeds selected period
// - Stop condition halts time-out counting
// - Overflow stops counter, clears enable, sets flag
// - Time-out raises the shared bus interrupt
// - Time-out resets bus logic and second control
// - Software may clear the time-out flag
// - Period is (select plus one) times 32
// - Enable bit 7, select bits 5-0, reset zero
// - Bit 6 reads time-out status
// - Address match captures direction, acks, sets flag
// - Interrupt sources told apart by flags
package i2c_tmo_pkg;
  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_OWN = 8'h04;
  localparam logic [7:0] ADDR_CTL1 = 8'h08;
  localparam logic [7:0] ADDR_CTL2 = 8'h0c;
  localparam logic [7:0] ADDR_TMO = 8'h10;
  localparam int TMO_EN_BIT = 7;
  localparam int TMO_FLAG_BIT = 6;
  localparam int C2_IRQ_BIT = 7;
  localparam int C2_MATCH_BIT = 6;
  localparam int C2_TXDIR_BIT = 4;
  localparam int C2_ACKTX_BIT = 3;
  localparam int C2_RW_BIT = 2;
  localparam int C2_MACK_BIT = 0;
  localparam int C1_EN_BIT = 0;
  localparam int SUB_DIV = 32;
  localparam logic [3:0] BYTE_END = 4'h8;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_AACK = 3'b010,
    ST_HOLD = 3'b011,
    ST_RX = 3'b100,
    ST_RACK = 3'b101,
    ST_TX = 3'b110,
    ST_TACK = 3'b111
  } bus_state_t;
endpackage

// *** i2c_slave_data_timeout.sv ***
// Two-wire bus slave: byte transfer, acknowledge, clock stretch, time-out.
// Assumes scl_in, sda_in and subclk already synchronous to pclk.
//
// Our own choices: the placing of the registers and the APB register port.
module i2c_slave_data_timeout import i2c_tmo_pkg::*; #(
  parameter int SUB_DIV_P = SUB_DIV
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial clock, open drain
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data, open drain
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Low-speed sub-clock and interrupt
  input wire logic subclk,
  output logic irq
);
  localparam int PW = $clog2(SUB_DIV_P);

  // Power of two only; the prescaler still compares against SUB_DIV_P - 1 to wrap
  if (SUB_DIV_P < 2 || (1 << PW) != SUB_DIV_P) begin : g_div_check
    $error("SUB_DIV_P must be a power of two of at least 2");
  end

  bus_state_t state_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic sda_low_r;
  logic scl_q, sda_q, sub_q;
  logic [7:0] data_buf_r;
  logic [6:0] own_addr_r;
  logic if_en_r;
  logic to_en_r, to_flag_r;
  logic [5:0] to_sel_r;
  logic tx_dir_r, ack_tx_r, match_r, rw_r, mack_r, irq_r;
  logic tmo_run_r;
  logic [PW-1:0] pre_r;
  logic [6:0] tmo_cnt_r;

  logic scl_rise, scl_fall, start_det, stop_det;
  logic acc, wr_data, rd_data, rel_p;
  logic match_p, rx_load, byte_p, tick, tmo_fire;

  assign scl_rise = scl_in & ~scl_q;
  assign scl_fall = ~scl_in & scl_q;
  assign start_det = scl_in & scl_q & sda_q & ~sda_in;
  assign stop_det = scl_in & scl_q & ~sda_q & sda_in;

  assign acc = psel & penable;
  assign wr_data = acc & pwrite & (paddr == ADDR_DATA);
  assign rd_data = acc & ~pwrite & (paddr == ADDR_DATA);
  // Only the access matching the direction frees the stretched clock
  assign rel_p = (state_r == ST_HOLD) &
                 ((tx_dir_r & wr_data) | (~tx_dir_r & rd_data));

  assign match_p = (state_r == ST_ADDR) & scl_fall & (cnt_r == BYTE_END) &
                   (shift_r[7:1] == own_addr_r);
  assign rx_load = (state_r == ST_RX) & scl_fall & (cnt_r == BYTE_END);
  assign byte_p = rx_load | ((state_r == ST_TACK) & scl_fall);

  assign tick = sub_q == 1'b0 && subclk &&
                pre_r == PW'(SUB_DIV_P - 1);
  // A clock fall in the firing cycle wins: it clears the count first
  assign tmo_fire = tmo_run_r & to_en_r & tick & ~scl_fall &
                    (tmo_cnt_r == {1'b0, to_sel_r});

  // Open drain: the pins only ever pull low
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = (state_r == ST_HOLD);
  assign sda_oe = sda_low_r;
  assign irq = irq_r;
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      sub_q <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      sub_q <= subclk;
    end
  end

  // Bus state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      sda_low_r <= 1'b0;
    end else if (tmo_fire || !if_en_r) begin
      state_r <= ST_IDLE;
      sda_low_r <= 1'b0;
    end else if (start_det) begin
      state_r <= ST_ADDR;
      cnt_r <= 4'h0;
      sda_low_r <= 1'b0;
    end else if (stop_det) begin
      state_r <= ST_IDLE;
      sda_low_r <= 1'b0;
    end else begin
      case (state_r)
        ST_ADDR: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_in};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_END) begin
            if (match_p) begin
              state_r <= ST_AACK;
              sda_low_r <= 1'b1;
            end else begin
              state_r <= ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          if (scl_fall) begin
            sda_low_r <= 1'b0;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (rel_p) begin
            cnt_r <= 4'h0;
            if (tx_dir_r) begin
              shift_r <= pwdata[7:0];
              sda_low_r <= ~pwdata[7];
              state_r <= ST_TX;
            end else begin
              state_r <= ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            shift_r <= {shift_r[6:0], sda_in};
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_END) begin
            sda_low_r <= ~ack_tx_r;
            state_r <= ST_RACK;
          end
        end
        ST_RACK: begin
          if (scl_fall) begin
            sda_low_r <= 1'b0;
            state_r <= ST_HOLD;
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall) begin
            if (cnt_r == BYTE_END) begin
              sda_low_r <= 1'b0;
              state_r <= ST_TACK;
            end else begin
              shift_r <= {shift_r[6:0], 1'b0};
              sda_low_r <= ~shift_r[6];
            end
          end
        end
        ST_TACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            // No acknowledge: line stays released until stop
            state_r <= mack_r ? ST_IDLE : ST_HOLD;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // Serial data buffer survives a time-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_buf_r <= 8'h00;
    end else if (rx_load) begin
      data_buf_r <= shift_r;
    end else if (wr_data) begin
      data_buf_r <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      own_addr_r <= 7'h00;
      if_en_r <= 1'b0;
    end else if (acc && pwrite) begin
      if (paddr == ADDR_OWN) begin
        own_addr_r <= pwdata[6:0];
      end
      if (paddr == ADDR_CTL1) begin
        if_en_r <= pwdata[C1_EN_BIT];
      end
    end
  end

  // Second control: back to reset values on time-out, pending bit set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_dir_r <= 1'b0;
      ack_tx_r <= 1'b0;
      match_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      irq_r <= 1'b0;
    end else if (tmo_fire) begin
      tx_dir_r <= 1'b0;
      ack_tx_r <= 1'b0;
      match_r <= 1'b0;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
      irq_r <= 1'b1;
    end else begin
      if (acc && pwrite && paddr == ADDR_CTL2) begin
        tx_dir_r <= pwdata[C2_TXDIR_BIT];
        ack_tx_r <= pwdata[C2_ACKTX_BIT];
        if (pwdata[C2_IRQ_BIT]) begin
          irq_r <= 1'b0;
        end
      end
      if (rel_p || stop_det) begin
        match_r <= 1'b0;
      end
      if (match_p) begin
        match_r <= 1'b1;
        rw_r <= shift_r[0];
      end
      if (state_r == ST_TACK && scl_rise) begin
        mack_r <= sda_in;
      end
      // Set wins over the write-one clear
      if (match_p || byte_p) begin
        irq_r <= 1'b1;
      end
    end
  end

  // Time-out control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_en_r <= 1'b0;
      to_flag_r <= 1'b0;
      to_sel_r <= 6'h00;
    end else begin
      if (acc && pwrite && paddr == ADDR_TMO) begin
        to_en_r <= pwdata[TMO_EN_BIT];
        to_flag_r <= pwdata[TMO_FLAG_BIT];
        to_sel_r <= pwdata[5:0];
      end
      if (tmo_fire) begin
        to_en_r <= 1'b0;
        to_flag_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmo_run_r <= 1'b0;
    end else if (tmo_fire || stop_det || !to_en_r) begin
      tmo_run_r <= 1'b0;
    end else if (match_p) begin
      tmo_run_r <= 1'b1;
    end
  end

  // Sub-clock divided down, restarted by every serial clock fall
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
      tmo_cnt_r <= 7'h00;
    end else if (!to_en_r || !tmo_run_r || scl_fall) begin
      pre_r <= '0;
      tmo_cnt_r <= 7'h00;
    end else if (!sub_q && subclk) begin
      if (pre_r == PW'(SUB_DIV_P - 1)) begin
        pre_r <= '0;
        tmo_cnt_r <= tmo_cnt_r + 7'h01;
      end else begin
        pre_r <= pre_r + PW'(1);
      end
    end
  end

  // Read data captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= 1'b0;
      case (paddr)
        ADDR_DATA: prdata <= {24'h0, data_buf_r};
        ADDR_OWN: prdata <= {25'h0, own_addr_r};
        ADDR_CTL1: prdata <= {31'h0, if_en_r};
        ADDR_CTL2: prdata <= {24'h0, irq_r, match_r, 1'b0, tx_dir_r,
                              ack_tx_r, rw_r, 1'b0, mack_r};
        ADDR_TMO: prdata <= {24'h0, to_en_r, to_flag_r, to_sel_r};
        default: begin
          prdata <= 32'h0;
          pslverr <= 1'b1;
        end
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_addr_ack_low: assert property (state_r == ST_AACK |-> sda_oe)
    else $error("address acknowledge not driven low");
  a_stretch_hold: assert property (
    state_r == ST_HOLD && !rel_p && !tmo_fire && !start_det && !stop_det
    && if_en_r |=> scl_oe)
    else $error("clock stretch dropped without service");
  a_nack_release: assert property (
    state_r == ST_TACK && scl_fall && mack_r && !start_det && !stop_det
    && !tmo_fire |=> !sda_oe && state_r == ST_IDLE)
    else $error("data line held after no acknowledge");
  a_fall_clears: assert property (scl_fall |=> tmo_cnt_r == 7'h00)
    else $error("clock fall did not clear time-out count");
  a_stop_halts: assert property (stop_det |=> !tmo_run_r)
    else $error("stop did not halt time-out");
  a_tmo_effects: assert property (tmo_fire |=>
    !to_en_r && to_flag_r && state_r == ST_IDLE && !tx_dir_r && irq)
    else $error("time-out effects missing");
  a_en_holds: assert property (!$past(to_en_r) && !to_en_r
    |-> tmo_cnt_r == 7'h00 && !tmo_run_r)
    else $error("time-out counter moved while disabled");
  a_match_start: assert property (
    match_p && to_en_r && !tmo_fire && !stop_det |=> tmo_run_r)
    else $error("address match did not start time-out");
  a_rx_load: assert property (rx_load |=>
    data_buf_r == $past(shift_r) && sda_oe == !$past(ack_tx_r))
    else $error("received byte or acknowledge wrong");

  c_addr_match: cover property (match_p);
  c_tx_byte: cover property (state_r == ST_TACK && scl_fall && !mack_r);
  c_timeout: cover property (tmo_fire);
endmodule

// *** i2c_master_model.sv ***
// Behavioural two-wire bus master driving the slave's serial pins.
// Assumes the bench resolves both open-drain wires with pull-ups.
module i2c_master_model (
  // Clock
  input wire logic pclk,
  // Resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // Pull-low enables and stuck-clock count
  output logic scl_low,
  output logic sda_low,
  output int stalls
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    stalls = 0;
  end
  task automatic hc();
    repeat (8) @(posedge pclk);
  endtask
  // Slave may stretch; bounded so a stuck clock ends the wait
  task automatic rel_scl();
    int k;
    scl_low <= 1'b0;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (scl !== 1'b1 && k < 2000);
    if (k >= 2000) stalls++;
    hc();
  endtask
  // Data moves two cycles after the fall, never with it
  task automatic xfer(input logic b, output logic r);
    repeat (2) @(posedge pclk);
    sda_low <= !b;
    hc();
    rel_scl();
    r = sda;
    scl_low <= 1'b1;
  endtask
  task automatic start();
    sda_low <= 1'b1;
    hc();
    scl_low <= 1'b1;
    hc();
  endtask
  task automatic stop();
    @(posedge pclk);
    sda_low <= 1'b1;
    hc();
    rel_scl();
    sda_low <= 1'b0;
    hc();
  endtask
  task automatic byte_x(input logic [7:0] d, input logic ack,
                        output logic [7:0] q, output logic ak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      xfer(d[i], r);
      q[i] = r;
    end
    xfer(ack, ak);
    hc();
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench: APB register tasks plus bus master transfers.
// Assumes the slave package and a divider of 2 for short time-outs.
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("unexpected %s exp %h got %h", nm, e, g); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import i2c_tmo_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ps;
  logic scl_out, scl_oe, sda_out, sda_oe, irq, m_scl, m_sda, ak;
  logic [7:0] paddr, q;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] sub_cnt = 5'h00;
  int err_total, checked, n, stalls;
  wire scl = !(scl_oe | m_scl);
  wire sda = !(sda_oe | m_sda);
  wire subclk = sub_cnt[4];
  i2c_slave_data_timeout #(.SUB_DIV_P(2)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .subclk(subclk),
    .irq(irq));
  i2c_master_model m (.pclk(pclk), .scl(scl), .sda(sda), .scl_low(m_scl),
    .sda_low(m_sda), .stalls(stalls));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // Sub-clock of 32 pclk periods: one tick every 64
  always @(posedge pclk) sub_cnt <= sub_cnt + 5'h01;
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    ps = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (k >= 20) begin
      err_total++;
      end_of_test();
    end
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    err_total = 0;
    checked = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_TMO, 0);
    `CHK("tmo reset", 8'h00, rd[7:0])
    apb(0, 8'h3c, 0);
    `CHK("slverr", 1'b1, ps)
    apb(1, ADDR_OWN, 32'h2a);
    apb(1, ADDR_CTL1, 32'h01);
    apb(1, ADDR_TMO, 32'h85);
    apb(0, ADDR_TMO, 0);
    `CHK("tmo rw", 8'h85, rd[7:0])
    $display("regs done");
    m.start();
    m.byte_x(8'h54, 1'b1, q, ak);
    `CHK("addr ack", 1'b0, ak)
    `CHK("stretch", 1'b1, scl_oe)
    `CHK("irq match", 1'b1, irq)
    apb(0, ADDR_CTL2, 0);
    `CHK("match rw", 2'b10, {rd[C2_MATCH_BIT], rd[C2_RW_BIT]})
    apb(1, ADDR_CTL2, 32'h80);
    apb(0, ADDR_DATA, 0);
    m.byte_x(8'ha5, 1'b1, q, ak);
    `CHK("data ack", 1'b0, ak)
    `CHK("irq byte", 1'b1, irq)
    apb(1, ADDR_CTL2, 32'h88);
    `CHK("irq clear", 1'b0, irq)
    apb(0, ADDR_DATA, 0);
    `CHK("rx byte", 8'ha5, rd[7:0])
    m.byte_x(8'h3c, 1'b1, q, ak);
    `CHK("data nack", 1'b1, ak)
    apb(0, ADDR_DATA, 0);
    m.stop();
    repeat (500) @(posedge pclk);
    apb(0, ADDR_TMO, 0);
    `CHK("halted", 8'h85, rd[7:0])
    $display("write done");
    m.start();
    m.byte_x(8'h55, 1'b1, q, ak);
    apb(0, ADDR_CTL2, 0);
    `CHK("read req", 1'b1, rd[C2_RW_BIT])
    apb(1, ADDR_CTL2, 32'h90);
    apb(1, ADDR_DATA, 32'hc3);
    m.byte_x(8'hff, 1'b0, q, ak);
    `CHK("tx byte", 8'hc3, q)
    apb(0, ADDR_CTL2, 0);
    `CHK("mack", 1'b0, rd[C2_MACK_BIT])
    apb(1, ADDR_CTL2, 32'h90);
    apb(1, ADDR_DATA, 32'h3c);
    m.byte_x(8'hff, 1'b1, q, ak);
    `CHK("tx byte2", 8'h3c, q)
    `CHK("sda free", 1'b0, sda_oe)
    `CHK("pins low", 2'b00, {scl_out, sda_out})
    apb(0, ADDR_CTL2, 0);
    `CHK("no mack", 1'b1, rd[C2_MACK_BIT])
    m.stop();
    $display("read done");
    apb(1, ADDR_TMO, 32'h81);
    m.start();
    m.byte_x(8'h54, 1'b1, q, ak);
    // Transmit and no-ack set, so only the time-out can free the clock
    apb(1, ADDR_CTL2, 32'h98);
    n = 12;
    while (scl_oe === 1'b1 && n < 400) begin
      @(posedge pclk);
      n++;
    end
    // Two ticks of 64 cycles after the last fall, plus the loop offset
    `CHK("tmo window", 1'b1, n >= 98 && n <= 133)
    `CHK("tmo irq", 1'b1, irq)
    apb(0, ADDR_TMO, 0);
    `CHK("tmo fired", 8'h41, rd[7:0])
    apb(0, ADDR_CTL2, 0);
    `CHK("ctl2 reset", 7'h00, rd[6:0])
    apb(0, ADDR_OWN, 0);
    `CHK("own kept", 8'h2a, rd[7:0])
    apb(0, ADDR_DATA, 0);
    `CHK("data kept", 8'h3c, rd[7:0])
    apb(0, ADDR_CTL1, 0);
    `CHK("ctl1 kept", 1'b1, rd[0])
    apb(1, ADDR_TMO, 32'h01);
    apb(0, ADDR_TMO, 0);
    `CHK("flag clear", 8'h01, rd[7:0])
    m.stop();
    m.start();
    m.byte_x(8'h54, 1'b1, q, ak);
    repeat (300) @(posedge pclk);
    `CHK("no tmo off", 1'b1, scl_oe)
    apb(0, ADDR_DATA, 0);
    m.stop();
    `CHK("stalls", 0, stalls)
    $display("timeout done");
    end_of_test();
  end
endmodule
